// ===== core/op_mode_pkg.sv
// operation mode controller package: modes, register map, timing
// assumes a 25 MHz clock and a 32-bit avalon-mm register slave
package op_mode_pkg;

   // ****************************************
   // modes
   // ****************************************
   typedef enum logic [1:0] {
      mode_sleep,
      mode_idle,
      mode_active,
      mode_limp
   } op_mode_t;

   // mode status field codes
   localparam logic [1:0] MODE_CODE_SLEEP  = 2'h0;
   localparam logic [1:0] MODE_CODE_LIMP   = 2'h1;
   localparam logic [1:0] MODE_CODE_ACTIVE = 2'h2;
   localparam logic [1:0] MODE_CODE_IDLE   = 2'h3;

   // ****************************************
   // register map (byte offsets)
   // ****************************************
   localparam logic [5:0] OFF_CTRL   = 6'h00;
   localparam logic [5:0] OFF_OUT    = 6'h04;
   localparam logic [5:0] OFF_MAP0   = 6'h08;
   localparam logic [5:0] OFF_MAP1   = 6'h0c;
   localparam logic [5:0] OFF_STATUS = 6'h10;
   localparam logic [5:0] OFF_ERR    = 6'h14;
   localparam logic [5:0] OFF_CMD    = 6'h18;

   // ctrl fields
   localparam int CTRL_ACT_BIT   = 0;
   localparam int CTRL_RST_BIT   = 1;
   localparam int CTRL_OPEN_LOAD_OFF_STATE_BIT_BIT = 2;

   // status fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_UV_BIT   = 2;
   localparam int STAT_LOP_BIT  = 3;
   localparam int STAT_TER_BIT  = 4;
   localparam int STAT_OSM_LSB  = 8;

   // reset values
   localparam logic [7:0] MAP0_RESET = 8'h04;
   localparam logic [7:0] MAP1_RESET = 8'h08;
   localparam logic [7:0] OUT_RESET  = 8'h00;

   // limp home channel mask: channels 2 and 3
   localparam logic [7:0] LIMP_MASK = 8'h0c;

   // transition latency to active or limp home
   localparam int TRANS_NS     = 200;
   localparam int CLK_NS       = 40;
   localparam int TRANS_CYCLES = (TRANS_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

// ===== core/op_mode_ctrl.sv
// operation mode controller for an eight channel high-side switch
// assumes pins asynchronous, supply monitors as levels, avalon-mm master
//
// Operation
// - four modes chosen from pins and bits
// - on request leave for active or limp
// - sleep: outputs off, registers at reset
// - idle: outputs off, registers and bus live
// - idle keeps channel error bits
// - standby high plus request enters active
// - force-active zero: no request returns idle
// - force-active one holds active
// - logic undervoltage, inputs low: active to idle
// - input high enters active even unmapped
// - standby low, input high: limp home
// - limp home: reads normal, writes ignored
// - limp home forces both supply flags
// - limp home mode field reads 01
// - first command in limp sets error flag
// - limp home holds open-load-off bit zero
// - limp: error and monitor bits normal
// - limp: other registers at default
// - limp: only channels 2, 3 on
// - turn-on delayed by mode transition time
// - power-on from supply and pin levels
// - soft reset: defaults, clear supply flags, keep errors
// - standby low resets registers and mapping
`timescale 1ns/100ps
module op_mode_ctrl (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // device pins
   input  wire logic        standby_pin,
   input  wire logic [1:0]  direct_input_pins,
   // supply monitors
   input  wire logic        logic_supply_ok,
   input  wire logic        logic_supply_low,
   input  wire logic        analog_supply_ok,
   input  wire logic        analog_supply_uv,
   // diagnosis
   input  wire logic [7:0]  channel_fault,
   input  wire logic [7:0]  output_status_monitor_bits,
   // avalon-mm slave
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // outputs
   output logic [7:0]       channel_enable,
   output logic [1:0]       mode_code,
   output logic             power_on,
   output logic             diag_enable
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic       stby_s1_r, stby_r;
   logic [1:0] in_s1_r, in_r;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stby_s1_r <= 1'b0;
         stby_r    <= 1'b0;
         in_s1_r   <= 2'h0;
         in_r      <= 2'h0;
      end else begin
         stby_s1_r <= standby_pin;
         stby_r    <= stby_s1_r;
         in_s1_r   <= direct_input_pins;
         in_r      <= in_s1_r;
      end
   end

   // ****************************************
   // state and registers
   // ****************************************
   op_mode_pkg::op_mode_t mode_r, mode_nxt;
   logic       force_active_bit, open_load_off_state_bit;
   logic [7:0] channel_on_bits, input_map_zero, input_map_one;
   logic [7:0] channel_error_bits;
   logic       supply_undervoltage_flag, logic_supply_low_power_flag;
   logic       transmission_error_flag, ter_pending_r;
   logic [3:0] trans_cnt_r;
   logic       power_on_nxt;
   logic       any_in, any_req, regs_live, limp, soft_rst, reg_clear;
   logic       acc_r, wr_ok, is_cmd;

   function automatic logic [7:0] map_inputs(input logic [1:0] ins, input logic [7:0] m0, input logic [7:0] m1);
      map_inputs = (ins[0] ? m0 : 8'h00) | (ins[1] ? m1 : 8'h00);
   endfunction

   assign any_in    = |in_r;
   assign any_req   = any_in | (|channel_on_bits);
   assign limp      = (mode_r == op_mode_pkg::mode_limp);
   assign regs_live = logic_supply_ok && (mode_r != op_mode_pkg::mode_sleep);
   assign power_on_nxt = (logic_supply_ok | analog_supply_ok) & (any_in | stby_r);
   assign wr_ok     = acc_r && write && !limp && regs_live;
   assign soft_rst  = wr_ok && address == op_mode_pkg::OFF_CTRL && writedata[op_mode_pkg::CTRL_RST_BIT];
   assign reg_clear = !regs_live || !stby_r || limp || soft_rst;
   assign is_cmd    = acc_r && (read || write);

   // ****************************************
   // mode machine
   // ****************************************
   always_comb begin
      mode_nxt = mode_r;
      if (!power_on) begin
         mode_nxt = op_mode_pkg::mode_sleep;
      end else begin
         unique case (mode_r)
            op_mode_pkg::mode_sleep,
            op_mode_pkg::mode_idle: begin
               if (!stby_r && any_in) begin
                  mode_nxt = op_mode_pkg::mode_limp;
               end else if (stby_r && any_req) begin
                  mode_nxt = op_mode_pkg::mode_active;
               end else if (stby_r) begin
                  mode_nxt = op_mode_pkg::mode_idle;
               end else begin
                  mode_nxt = op_mode_pkg::mode_sleep;
               end
            end
            op_mode_pkg::mode_active: begin
               if (!stby_r && any_in) begin
                  mode_nxt = op_mode_pkg::mode_limp;
               end else if (!stby_r) begin
                  mode_nxt = op_mode_pkg::mode_sleep;
               end else if (!logic_supply_ok && !any_in) begin
                  mode_nxt = op_mode_pkg::mode_idle;
               end else if (!force_active_bit && !any_req) begin
                  mode_nxt = op_mode_pkg::mode_idle;
               end
               // force_active_bit keeps active
            end
            op_mode_pkg::mode_limp: begin
               if (stby_r && any_req) begin
                  mode_nxt = op_mode_pkg::mode_active;
               end else if (stby_r) begin
                  mode_nxt = op_mode_pkg::mode_idle;
               end else if (!any_in) begin
                  mode_nxt = op_mode_pkg::mode_sleep;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_r   <= op_mode_pkg::mode_sleep;
         power_on <= 1'b0;
      end else begin
         mode_r   <= mode_nxt;
         power_on <= power_on_nxt;
      end
   end

   // transition latency counter
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         trans_cnt_r <= 4'h0;
      end else if (mode_nxt != mode_r &&
                   (mode_nxt == op_mode_pkg::mode_active || mode_nxt == op_mode_pkg::mode_limp) &&
                   !(mode_r == op_mode_pkg::mode_active || mode_r == op_mode_pkg::mode_limp)) begin
         trans_cnt_r <= 4'(op_mode_pkg::TRANS_CYCLES);
      end else if (trans_cnt_r != 4'h0) begin
         trans_cnt_r <= trans_cnt_r - 4'h1;
      end
   end

   // ****************************************
   // channel outputs
   // ****************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         channel_enable <= 8'h00;
         diag_enable    <= 1'b0;
         mode_code      <= op_mode_pkg::MODE_CODE_SLEEP;
      end else begin
         diag_enable <= (mode_r == op_mode_pkg::mode_active) || limp;
         unique case (mode_r)
            op_mode_pkg::mode_active: mode_code <= op_mode_pkg::MODE_CODE_ACTIVE;
            op_mode_pkg::mode_limp:   mode_code <= op_mode_pkg::MODE_CODE_LIMP;
            op_mode_pkg::mode_idle:   mode_code <= op_mode_pkg::MODE_CODE_IDLE;
            op_mode_pkg::mode_sleep:  mode_code <= op_mode_pkg::MODE_CODE_SLEEP;
         endcase
         if (trans_cnt_r != 4'h0 || !analog_supply_ok) begin
            channel_enable <= 8'h00;
         end else if (mode_r == op_mode_pkg::mode_active) begin
            channel_enable <= (channel_on_bits | map_inputs(in_r, input_map_zero, input_map_one)) & ~channel_error_bits;
         end else if (limp) begin
            channel_enable <= map_inputs(in_r, op_mode_pkg::MAP0_RESET, op_mode_pkg::MAP1_RESET)
                              & op_mode_pkg::LIMP_MASK & ~channel_error_bits;
         end else begin
            channel_enable <= 8'h00;
         end
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         force_active_bit        <= 1'b0;
         open_load_off_state_bit <= 1'b0;
         channel_on_bits         <= op_mode_pkg::OUT_RESET;
         input_map_zero          <= op_mode_pkg::MAP0_RESET;
         input_map_one           <= op_mode_pkg::MAP1_RESET;
      end else if (reg_clear) begin
         force_active_bit        <= 1'b0;
         open_load_off_state_bit <= 1'b0;
         channel_on_bits         <= op_mode_pkg::OUT_RESET;
         input_map_zero          <= op_mode_pkg::MAP0_RESET;
         input_map_one           <= op_mode_pkg::MAP1_RESET;
      end else if (wr_ok) begin
         unique case (address)
            6'(op_mode_pkg::OFF_CTRL): begin
               force_active_bit        <= writedata[op_mode_pkg::CTRL_ACT_BIT];
               open_load_off_state_bit <= writedata[op_mode_pkg::CTRL_OPEN_LOAD_OFF_STATE_BIT_BIT];
            end
            6'(op_mode_pkg::OFF_OUT):  channel_on_bits <= writedata[7:0];
            6'(op_mode_pkg::OFF_MAP0): input_map_zero  <= writedata[7:0];
            6'(op_mode_pkg::OFF_MAP1): input_map_one   <= writedata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // flags
   // ****************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         channel_error_bits <= 8'h00;
      end else if (mode_r == op_mode_pkg::mode_active || limp) begin
         // set wins over write-one clear; held in idle
         channel_error_bits <= (channel_error_bits & ~((wr_ok && address == op_mode_pkg::OFF_ERR)
                                ? writedata[7:0] : 8'h00)) | channel_fault;
      end else if (wr_ok && address == op_mode_pkg::OFF_ERR) begin
         channel_error_bits <= channel_error_bits & ~writedata[7:0];
      end
   end

   // status read clears supply flags; live condition wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         supply_undervoltage_flag    <= 1'b0;
         logic_supply_low_power_flag <= 1'b0;
      end else if (limp) begin
         supply_undervoltage_flag    <= 1'b1;
         logic_supply_low_power_flag <= 1'b1;
      end else if (soft_rst || !regs_live) begin
         supply_undervoltage_flag    <= 1'b0;
         logic_supply_low_power_flag <= 1'b0;
      end else begin
         supply_undervoltage_flag <= analog_supply_uv ||
            (supply_undervoltage_flag && !(acc_r && read && address == op_mode_pkg::OFF_STATUS));
         logic_supply_low_power_flag <= logic_supply_low ||
            (logic_supply_low_power_flag && !(acc_r && read && address == op_mode_pkg::OFF_STATUS));
      end
   end

   // error flag: set on first command in limp, else set by bad command address
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ter_pending_r           <= 1'b0;
         transmission_error_flag <= 1'b0;
      end else begin
         if (mode_nxt == op_mode_pkg::mode_limp && !limp) begin
            ter_pending_r <= 1'b1;
         end else if (is_cmd || !limp) begin
            ter_pending_r <= 1'b0;
         end
         if (is_cmd && ter_pending_r) begin
            transmission_error_flag <= 1'b1;
         end else if (is_cmd && address > op_mode_pkg::OFF_CMD) begin
            transmission_error_flag <= 1'b1;
         end else if (acc_r && read && address == op_mode_pkg::OFF_STATUS) begin
            transmission_error_flag <= 1'b0;
         end
      end
   end

   // ****************************************
   // avalon-mm slave, one wait state
   // ****************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         acc_r       <= 1'b0;
         waitrequest <= 1'b1;
      end else begin
         acc_r       <= (read || write) && !acc_r;
         waitrequest <= !((read || write) && !acc_r);
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         readdata <= op_mode_pkg::UNMAPPED_DATA;
      end else if (read && !acc_r) begin
         unique case (address)
            6'(op_mode_pkg::OFF_CTRL):
               readdata <= {29'h0, open_load_off_state_bit, 1'b0, force_active_bit};
            6'(op_mode_pkg::OFF_OUT):  readdata <= {24'h0, channel_on_bits};
            6'(op_mode_pkg::OFF_MAP0): readdata <= {24'h0, input_map_zero};
            6'(op_mode_pkg::OFF_MAP1): readdata <= {24'h0, input_map_one};
            op_mode_pkg::OFF_STATUS:
               readdata <= {16'h0, output_status_monitor_bits, 3'h0, transmission_error_flag,
                            logic_supply_low_power_flag, supply_undervoltage_flag, mode_code};
            op_mode_pkg::OFF_ERR:    readdata <= {24'h0, channel_error_bits};
            default:                 readdata <= op_mode_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   limp_mask_a: assert property (@(posedge clock) disable iff (reset)
      limp |=> (channel_enable & ~op_mode_pkg::LIMP_MASK) == 8'h00)
      else $error("channel outside limp mask enabled");
   sleep_off_a: assert property (@(posedge clock) disable iff (reset)
      mode_r == op_mode_pkg::mode_sleep |=> channel_enable == 8'h00)
      else $error("channel on in sleep");
   idle_off_a: assert property (@(posedge clock) disable iff (reset)
      mode_r == op_mode_pkg::mode_idle |=> channel_enable == 8'h00 && !diag_enable)
      else $error("channel or diag on in idle");
   limp_flags_a: assert property (@(posedge clock) disable iff (reset)
      limp |=> supply_undervoltage_flag && logic_supply_low_power_flag && mode_code == 2'h1)
      else $error("limp flags wrong");
   limp_write_a: assert property (@(posedge clock) disable iff (reset)
      limp && $stable(mode_r) |=> force_active_bit == 1'b0 && channel_on_bits == op_mode_pkg::OUT_RESET)
      else $error("register changed in limp");
   force_hold_a: assert property (@(posedge clock) disable iff (reset)
      mode_r == op_mode_pkg::mode_active && force_active_bit && stby_r && logic_supply_ok && power_on
      |=> mode_r == op_mode_pkg::mode_active)
      else $error("left active with force bit");
   enter_active_a: assert property (@(posedge clock) disable iff (reset)
      power_on && stby_r && any_in && mode_r == op_mode_pkg::mode_idle |=> mode_r == op_mode_pkg::mode_active)
      else $error("active not entered");
   idle_return_a: assert property (@(posedge clock) disable iff (reset)
      power_on && stby_r && !force_active_bit && !any_req && mode_r == op_mode_pkg::mode_active
      |=> mode_r == op_mode_pkg::mode_idle)
      else $error("idle not reached");
   turn_on_delay_a: assert property (@(posedge clock) disable iff (reset)
      mode_r == op_mode_pkg::mode_idle && mode_nxt == op_mode_pkg::mode_active |=> ##1 channel_enable == 8'h00)
      else $error("turn-on without transition delay");
   limp_ter_a: assert property (@(posedge clock) disable iff (reset)
      limp && is_cmd && ter_pending_r |=> transmission_error_flag)
      else $error("error flag not set on first limp command");
   soft_keep_a: assert property (@(posedge clock) disable iff (reset)
      soft_rst && mode_r == op_mode_pkg::mode_idle
      |=> $stable(channel_error_bits) && input_map_zero == op_mode_pkg::MAP0_RESET)
      else $error("soft reset lost error bits or kept map");
   power_off_a: assert property (@(posedge clock) disable iff (reset)
      !power_on |=> mode_r == op_mode_pkg::mode_sleep)
      else $error("awake without power-on");
   enter_active_c: cover property (@(posedge clock) disable iff (reset)
      mode_r == op_mode_pkg::mode_idle ##1 mode_r == op_mode_pkg::mode_active);
   enter_limp_c: cover property (@(posedge clock) disable iff (reset) !limp ##1 limp);
   limp_ter_c: cover property (@(posedge clock) disable iff (reset) limp && is_cmd && ter_pending_r);
   soft_reset_c: cover property (@(posedge clock) disable iff (reset) soft_rst);
   force_hold_c: cover property (@(posedge clock) disable iff (reset)
      mode_r == op_mode_pkg::mode_active && force_active_bit && !any_req);

endmodule

// ===== tb/host_model.sv
// host model: avalon-mm master and pin driver facing the mode controller
// assumes a registered waitrequest slave sharing one rising-edge clock
`timescale 1ns/100ps
module host_model (
   // clock
   input  wire logic        clock,
   // avalon-mm master
   output logic [5:0]       address,
   output logic             read,
   output logic             write,
   output logic [31:0]      writedata,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest,
   // device pins
   output logic             standby_pin,
   output logic [1:0]       direct_input_pins
);
   // ****************************************
   // idle levels at time zero
   // ****************************************
   initial begin
      address           = 6'h00;
      read              = 1'b0;
      write             = 1'b0;
      writedata         = 32'h0000_0000;
      standby_pin       = 1'b0;
      direct_input_pins = 2'b00;
   end
   // ****************************************
   // bus cycles, held until waitrequest low
   // ****************************************
   task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
      @(posedge clock);
      address   <= a;
      writedata <= d;
      write     <= 1'b1;
      do @(posedge clock); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
      @(posedge clock);
      address <= a;
      read    <= 1'b1;
      do @(posedge clock); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask
   // ****************************************
   // pin levels
   // ****************************************
   task automatic set_pins(input logic s, input logic [1:0] p);
      @(posedge clock);
      standby_pin       <= s;
      direct_input_pins <= p;
   endtask
endmodule

// ===== tb/operation_mode_controller_test.sv
// testbench: mode controller against the host model
// assumes the design's in-file assertions and a 25 MHz clock
`timescale 1ns/100ps
module operation_mode_controller_test;
   // ****************************************
   // signals and constants
   // ****************************************
   localparam logic [1:0] M_SLP = op_mode_pkg::MODE_CODE_SLEEP;
   localparam logic [1:0] M_IDL = op_mode_pkg::MODE_CODE_IDLE;
   localparam logic [1:0] M_ACT = op_mode_pkg::MODE_CODE_ACTIVE;
   localparam logic [1:0] M_LMP = op_mode_pkg::MODE_CODE_LIMP;
   localparam int         SETTLE = op_mode_pkg::TRANS_CYCLES + 3;
   typedef struct packed {
      logic [7:0] out;
      logic       act;
      logic [1:0] pins;
      logic [1:0] mode;
      logic [7:0] ch;
   } row_t;
   logic        clock, reset, lso, lsl, aso, asu;
   logic [7:0]  fault, osm, ch;
   logic [5:0]  address;
   logic        read, write, waitrequest, standby_pin, power_on, diag_enable;
   logic [31:0] writedata, readdata, rd;
   logic [1:0]  pins, mode;
   int          err_total, n_checks;
   row_t        rows [5] = '{
      '{8'h81, 1'b0, 2'b00, M_ACT, 8'h81},
      '{8'h00, 1'b0, 2'b00, M_IDL, 8'h00},
      '{8'h00, 1'b0, 2'b01, M_ACT, 8'h04},
      '{8'h00, 1'b1, 2'b00, M_ACT, 8'h00},
      '{8'h00, 1'b0, 2'b00, M_IDL, 8'h00}};
   // ****************************************
   // instances
   // ****************************************
   op_mode_ctrl u_dut (.clock(clock), .reset(reset), .standby_pin(standby_pin), .direct_input_pins(pins),
      .logic_supply_ok(lso), .logic_supply_low(lsl), .analog_supply_ok(aso), .analog_supply_uv(asu),
      .channel_fault(fault), .output_status_monitor_bits(osm), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .channel_enable(ch), .mode_code(mode), .power_on(power_on), .diag_enable(diag_enable));
   host_model u_host (.clock(clock), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .standby_pin(standby_pin), .direct_input_pins(pins));
   // ****************************************
   // helpers
   // ****************************************
   initial clock = 1'b0;
   always #20 clock = ~clock;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 60 && mode !== m; i++) @(posedge clock);
      chk(mode, m, "mode");
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      err_total++;
      wrap_up();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset = 1'b1; lso = 1'b1; lsl = 1'b0; aso = 1'b1; asu = 1'b0;
      fault = 8'h00; osm = 8'h00; err_total = 0; n_checks = 0;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk(mode, M_SLP, "sleep mode");
      chk(ch, 8'h00, "sleep channels");
      u_host.set_pins(1'b1, 2'b00);
      wait_mode(M_IDL);
      chk(power_on, 1'b1, "power on");
      chk(diag_enable, 1'b0, "idle diag");
      u_host.bus_read(6'h1c, rd);
      chk(rd, op_mode_pkg::UNMAPPED_DATA, "unmapped");
      foreach (rows[i]) begin
         u_host.bus_write(6'(op_mode_pkg::OFF_CTRL), {31'h0, rows[i].act});
         u_host.bus_write(6'(op_mode_pkg::OFF_OUT), {24'h0, rows[i].out});
         u_host.set_pins(1'b1, rows[i].pins);
         wait_mode(rows[i].mode);
         repeat (SETTLE) @(posedge clock);
         chk(ch, rows[i].ch, "row channels");
         chk(diag_enable, rows[i].mode == M_ACT, "row diag");
      end
      u_host.bus_write(6'(op_mode_pkg::OFF_MAP0), 32'h0000_0000);
      u_host.bus_write(6'(op_mode_pkg::OFF_MAP1), 32'h0000_0000);
      u_host.set_pins(1'b1, 2'b01);
      wait_mode(M_ACT);
      repeat (SETTLE) @(posedge clock);
      chk(ch, 8'h00, "unmapped input");
      u_host.set_pins(1'b1, 2'b00);
      wait_mode(M_IDL);
      u_host.bus_write(6'(op_mode_pkg::OFF_OUT), 32'h0000_0002);
      wait_mode(M_ACT);
      chk(ch, 8'h00, "turn-on latency");
      repeat (SETTLE) @(posedge clock);
      chk(ch, 8'h02, "turned on");
      fault <= 8'h02;
      repeat (2) @(posedge clock);
      fault <= 8'h00;
      u_host.bus_write(6'(op_mode_pkg::OFF_OUT), 32'h0000_0000);
      wait_mode(M_IDL);
      u_host.bus_read(6'(op_mode_pkg::OFF_ERR), rd);
      chk(rd, 32'h0000_0002, "idle error bits");
      u_host.bus_write(6'(op_mode_pkg::OFF_MAP0), 32'h0000_0055);
      u_host.bus_write(6'(op_mode_pkg::OFF_CTRL), 32'h0000_0002);
      u_host.bus_read(6'(op_mode_pkg::OFF_MAP0), rd);
      chk(rd, {24'h0, op_mode_pkg::MAP0_RESET}, "soft reset map");
      u_host.bus_read(6'(op_mode_pkg::OFF_ERR), rd);
      chk(rd, 32'h0000_0002, "soft reset errors");
      u_host.bus_read(6'(op_mode_pkg::OFF_STATUS), rd);
      chk(rd, 32'h0000_0013, "idle status");
      u_host.bus_write(6'(op_mode_pkg::OFF_OUT), 32'h0000_0020);
      wait_mode(M_ACT);
      lso <= 1'b0;
      wait_mode(M_IDL);
      chk(ch, 8'h00, "undervoltage channels");
      lso <= 1'b1;
      u_host.bus_write(6'(op_mode_pkg::OFF_CTRL), 32'h0000_0004);
      osm <= 8'ha5;
      u_host.set_pins(1'b0, 2'b10);
      wait_mode(M_LMP);
      repeat (SETTLE) @(posedge clock);
      chk(ch, 8'h08, "limp channels");
      u_host.bus_read(6'(op_mode_pkg::OFF_ERR), rd);
      chk(rd, 32'h0000_0002, "limp error bits");
      u_host.bus_read(6'(op_mode_pkg::OFF_STATUS), rd);
      chk(rd, 32'h0000_a51d, "limp status");
      u_host.bus_write(6'(op_mode_pkg::OFF_OUT), 32'h0000_00ff);
      u_host.bus_read(6'(op_mode_pkg::OFF_OUT), rd);
      chk(rd, {24'h0, op_mode_pkg::OUT_RESET}, "limp write");
      u_host.bus_read(6'(op_mode_pkg::OFF_CTRL), rd);
      chk(rd, 32'h0000_0000, "limp ctrl");
      chk(ch, 8'h08, "limp after write");
      u_host.bus_read(6'(op_mode_pkg::OFF_STATUS), rd);
      chk(rd, 32'h0000_a50d, "limp status again");
      u_host.set_pins(1'b0, 2'b00);
      wait_mode(M_SLP);
      chk(ch, 8'h00, "sleep again");
      chk(power_on, 1'b0, "power off");
      u_host.set_pins(1'b1, 2'b01);
      wait_mode(M_ACT);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      chk(ch, 8'h00, "reset channels");
      chk(mode, M_SLP, "reset mode");
      reset <= 1'b0;
      @(posedge clock);
      chk(waitrequest, 1'b1, "reset bus idle");
      chk(mode, M_SLP, "first edge mode");
      wait_mode(M_ACT);
      repeat (SETTLE) @(posedge clock);
      chk(ch, 8'h04, "after reset");
      wrap_up();
   end
endmodule
